/* hw/pdt_pkg.sv */
package pdt_pkg;
    // ---------------------------------------------------------------
    // register bus geometry
    // ---------------------------------------------------------------
    localparam int AW = 3;
    localparam int DW = 8;

    // ---------------------------------------------------------------
    // register offsets
    // ---------------------------------------------------------------
    localparam logic [AW-1:0] ADDR_CTRL = 3'h0;
    localparam logic [AW-1:0] ADDR_PRESET0 = 3'h1;
    localparam logic [AW-1:0] ADDR_PRESET1 = 3'h2;
    localparam logic [AW-1:0] ADDR_CNT_LO = 3'h3;
    localparam logic [AW-1:0] ADDR_CNT_HI = 3'h4;
    localparam logic [AW-1:0] ADDR_STATUS = 3'h5;
    localparam logic [AW-1:0] ADDR_MASK = 3'h6;

    // ---------------------------------------------------------------
    // control register fields
    // ---------------------------------------------------------------
    localparam int CTRL_RUN0 = 0;
    localparam int CTRL_RUN1 = 1;
    localparam int CTRL_CASCADE = 2;
    localparam int CTRL_EVENT = 3;
    localparam int CTRL_OUT_EN = 4;
    localparam int CTRL_OSC_ON = 5;
    localparam int CTRL_SRC_HS = 6;

    // ---------------------------------------------------------------
    // status and mask fields
    // ---------------------------------------------------------------
    localparam int ST_UF0 = 0;
    localparam int ST_UF1 = 1;
    localparam int ST_W = 2;

    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic [DW-1:0] CTRL_RESET = 8'h00;
    localparam logic [DW-1:0] PRESET_RESET = 8'hff;
    localparam logic [DW-1:0] COUNT_RESET = 8'hff;
    localparam logic [ST_W-1:0] MASK_RESET = 2'h0;
    localparam logic [DW-1:0] ZERO_BYTE = 8'h00;
    localparam logic [DW-1:0] ONE_BYTE = 8'h01;
endpackage

/* hw/pdt_channel.sv */
module pdt_channel (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // count timing
    input wire logic tick,
    input wire logic cnt_en,
    input wire logic event_mode,
    // software access
    input wire logic run_wr,
    input wire logic run_wdata,
    input wire logic preset_wr,
    input wire logic [pdt_pkg::DW-1:0] load_value,
    input wire logic [pdt_pkg::DW-1:0] preset,
    // state
    output logic [pdt_pkg::DW-1:0] count,
    output logic running,
    output logic underflow
);
    import pdt_pkg::*;

    logic run_req;
    logic active;
    logic step;

    // ---------------------------------------------------------------
    // run control
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_req <= 1'b0;
        end else if (run_wr) begin
            run_req <= run_wdata;
        end
    end

    // outside event mode the request only reaches the counter on a falling input edge; in event mode it follows every clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            active <= 1'b0;
        end else if (event_mode) begin
            active <= run_req;
        end else if (tick) begin
            active <= run_req;
        end
    end

    // still active on the stopping edge, so one last decrement happens
    assign step = tick && cnt_en && (event_mode ? run_req : active);
    // event counting has no edge sync, so read-back follows the request at once
    assign running = event_mode ? run_req : (run_req | active);
    assign underflow = step && (count == ZERO_BYTE);

    // ---------------------------------------------------------------
    // counter
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= COUNT_RESET;
        end else if (underflow) begin
            count <= preset;
        end else if (step) begin
            count <= count - ONE_BYTE;
        end else if (preset_wr && !running) begin
            count <= load_value;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    run_on_edge_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!event_mode && !tick) |=> (active == $past(active)))
        else $error("run state changed without an input clock edge");

    last_decrement_a: assert property (@(posedge clk) disable iff (!rst_n)
        (tick && cnt_en && active && !run_req && !event_mode && count != ZERO_BYTE)
        |=> (!active && count == $past(count) - ONE_BYTE))
        else $error("stop did not take one final decrement");

    run_readback_a: assert property (@(posedge clk) disable iff (!rst_n)
        (active && !run_req && !tick && !event_mode) |=> (running || event_mode))
        else $error("run bit read back zero before stopping");

    event_direct_a: assert property (@(posedge clk) disable iff (!rst_n)
        (event_mode && $past(event_mode)) |-> (active == $past(run_req)))
        else $error("event mode run control was delayed");

    preset_reload_a: assert property (@(posedge clk) disable iff (!rst_n)
        (step && count == ZERO_BYTE) |=> (count == $past(preset)))
        else $error("underflow did not reload preset");
endmodule

/* hw/pdt_top.sv */
// Function
// - run bit changes take effect on the next falling edge of input clock
// - after run is cleared the counter decrements once more, then stops
// - run bit reads one until the counter has really stopped
// - event counter mode applies run control directly, without edge sync
// - square wave pin gated asynchronously by its enable; short glitch possible
// - fast oscillator is off after reset
module pdt_top (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [pdt_pkg::AW-1:0] addr,
    input wire logic [pdt_pkg::DW-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [pdt_pkg::DW-1:0] rdata,
    // count clock sources
    input wire logic slow_clk_in,
    input wire logic high_speed_osc_clk,
    input wire logic event_in,
    // outputs
    output logic high_speed_oscillator_on,
    output logic timer_output_pin,
    output logic irq
);
    import pdt_pkg::*;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic fell(input logic prev, input logic now);
        return prev && !now;
    endfunction

    function automatic logic hit(input logic strobe, input logic [AW-1:0] a,
                                 input logic [AW-1:0] target);
        return strobe && (a == target);
    endfunction

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic [2:0] slow_sync;
    logic [2:0] hs_sync;
    logic [2:0] ev_sync;

    // stage 0 is only read by stage 1; edges are taken from stages 1 and 2
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slow_sync <= 3'h0;
            hs_sync <= 3'h0;
            ev_sync <= 3'h0;
        end else begin
            slow_sync <= {slow_sync[1:0], slow_clk_in};
            hs_sync <= {hs_sync[1:0], high_speed_osc_clk};
            ev_sync <= {ev_sync[1:0], event_in};
        end
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic [DW-1:0] ctrl;
    logic [DW-1:0] preset0;
    logic [DW-1:0] preset1;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] mask;
    logic [DW-1:0] hi_snap;
    logic timer_square_wave;

    logic wr_ctrl;
    logic wr_p0;
    logic wr_p1;
    logic rd_status;
    logic rd_lo;

    assign wr_ctrl = hit(wr, addr, ADDR_CTRL);
    assign wr_p0 = hit(wr, addr, ADDR_PRESET0);
    assign wr_p1 = hit(wr, addr, ADDR_PRESET1);
    assign rd_status = hit(rd, addr, ADDR_STATUS);
    assign rd_lo = hit(rd, addr, ADDR_CNT_LO);

    // run bits read back from the channels; ctrl still stores the whole written byte
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl <= wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            preset0 <= PRESET_RESET;
            preset1 <= PRESET_RESET;
        end else begin
            if (wr_p0) begin
                preset0 <= wdata;
            end
            if (wr_p1) begin
                preset1 <= wdata;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask <= MASK_RESET;
        end else if (hit(wr, addr, ADDR_MASK)) begin
            mask <= wdata[ST_W-1:0];
        end
    end

    assign high_speed_oscillator_on = ctrl[CTRL_OSC_ON];

    // ---------------------------------------------------------------
    // clock selection and cascade
    // ---------------------------------------------------------------
    logic cascade;
    logic event_mode;
    logic clk_fall;
    logic tick0;
    logic tick1;
    logic en1;
    logic uf0;
    logic uf1;
    logic uf_src;
    logic run0;
    logic run1;
    logic [DW-1:0] count0;
    logic [DW-1:0] count1;

    assign cascade = ctrl[CTRL_CASCADE];
    assign event_mode = ctrl[CTRL_EVENT];
    // a stopped oscillator gives no edges, so gate it by its enable
    assign clk_fall = ctrl[CTRL_SRC_HS]
                    ? (ctrl[CTRL_OSC_ON] && fell(hs_sync[2], hs_sync[1]))
                    : fell(slow_sync[2], slow_sync[1]);
    assign tick0 = event_mode ? fell(ev_sync[2], ev_sync[1]) : clk_fall;
    assign tick1 = cascade ? tick0 : clk_fall;
    assign en1 = cascade ? uf0 : 1'b1;
    assign uf_src = cascade ? uf1 : uf0;

    pdt_channel u_ch0 (
        .clk(clk),
        .rst_n(rst_n),
        .tick(tick0),
        .cnt_en(1'b1),
        .event_mode(event_mode),
        .run_wr(wr_ctrl),
        .run_wdata(wdata[CTRL_RUN0]),
        .preset_wr(wr_p0),
        .load_value(wdata),
        .preset(preset0),
        .count(count0),
        .running(run0),
        .underflow(uf0)
    );

    pdt_channel u_ch1 (
        .clk(clk),
        .rst_n(rst_n),
        .tick(tick1),
        .cnt_en(en1),
        .event_mode(cascade && event_mode),
        .run_wr(wr_ctrl),
        .run_wdata(wdata[CTRL_RUN1]),
        .preset_wr(wr_p1),
        .load_value(wdata),
        .preset(preset1),
        .count(count1),
        .running(run1),
        .underflow(uf1)
    );

    // ---------------------------------------------------------------
    // square wave
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_square_wave <= 1'b0;
        end else if (uf_src) begin
            timer_square_wave <= !timer_square_wave;
        end
    end

    // plain gate, not resynchronised: enabling mid-phase can clip a pulse
    assign timer_output_pin = timer_square_wave & ctrl[CTRL_OUT_EN];

    // ---------------------------------------------------------------
    // interrupt status
    // ---------------------------------------------------------------
    // a new underflow in the clearing read's cycle survives the clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status <= '0;
        end else begin
            status <= (rd_status ? '0 : status) | {uf1, uf0};
        end
    end

    assign irq = |(status & mask);

    // ---------------------------------------------------------------
    // read path
    // ---------------------------------------------------------------
    // in cascade mode a low byte read freezes the high byte so the pair is coherent
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hi_snap <= ZERO_BYTE;
        end else if (rd_lo) begin
            hi_snap <= count1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= ZERO_BYTE;
        end else if (rd) begin
            unique case (addr)
                ADDR_CTRL: begin
                    rdata <= {ctrl[DW-1:CTRL_RUN1+1], run1, run0};
                end
                ADDR_PRESET0: begin
                    rdata <= preset0;
                end
                ADDR_PRESET1: begin
                    rdata <= preset1;
                end
                ADDR_CNT_LO: begin
                    rdata <= count0;
                end
                ADDR_CNT_HI: begin
                    rdata <= cascade ? hi_snap : count1;
                end
                ADDR_STATUS: begin
                    rdata <= {{(DW-ST_W){1'b0}}, status};
                end
                ADDR_MASK: begin
                    rdata <= {{(DW-ST_W){1'b0}}, mask};
                end
                default: begin
                    rdata <= ZERO_BYTE;
                end
            endcase
        end else begin
            rdata <= ZERO_BYTE;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    osc_reset_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        ($past(rst_n) == 1'b0) |-> !high_speed_oscillator_on)
        else $error("fast oscillator not off after reset");

    osc_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ctrl[CTRL_SRC_HS] && !ctrl[CTRL_OSC_ON]) |-> !clk_fall)
        else $error("count tick from a stopped fast oscillator");

    wave_toggle_a: assert property (@(posedge clk) disable iff (!rst_n)
        (uf_src && ctrl[CTRL_OUT_EN] && !wr_ctrl)
        |=> (timer_output_pin != $past(timer_output_pin)))
        else $error("pin did not follow square wave toggle");

    wave_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        !uf_src |=> (timer_square_wave == $past(timer_square_wave)))
        else $error("square wave toggled without an underflow");

    pin_gated_a: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_ctrl && !wdata[CTRL_OUT_EN]) |=> !timer_output_pin)
        else $error("pin active with enable cleared");

    underflow_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        (uf0 || uf1) |=> (status != '0) ##0 (irq == |(status & mask)))
        else $error("underflow did not set status");

    read_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_status && !uf0 && !uf1) |=> (status == '0 && !irq))
        else $error("status read did not clear flags");

    // a flag raised in the clearing read's own cycle must not be lost
    set_wins_a: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_status && (uf0 || uf1)) |=> (status == $past({uf1, uf0})))
        else $error("underflow lost to a clearing status read");

    cascade_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cascade && !uf0 && !wr_p1) |=> (count1 == $past(count1)))
        else $error("high byte moved without a low byte underflow");

    snap_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        !rd_lo |=> (hi_snap == $past(hi_snap)))
        else $error("high byte latch changed without a low byte read");

    read_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
        !rd |=> (rdata == ZERO_BYTE))
        else $error("read data stood longer than one cycle");
endmodule

/* testbench/pdt_tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import pdt_pkg::*;
    // ---------------------------------------------------------------
    // stimulus, observation and counters
    // ---------------------------------------------------------------
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [AW-1:0] addr = 3'h0;
    logic [DW-1:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    // source pins idle high so the first drop is a falling edge
    logic [2:0] pins = 3'h7;
    logic [DW-1:0] rdata;
    logic osc_on;
    logic pin_out;
    logic irq;
    int err_total = 0;
    int checked = 0;
    int cycles = 0;
    logic [DW-1:0] v;
    logic [DW-1:0] h;

    pdt_top DUT (
        .clk(clk),
        .rst_n(rst_n),
        .addr(addr),
        .wdata(wdata),
        .wr(wr),
        .rd(rd),
        .rdata(rdata),
        .slow_clk_in(pins[0]),
        .high_speed_osc_clk(pins[1]),
        .event_in(pins[2]),
        .high_speed_oscillator_on(osc_on),
        .timer_output_pin(pin_out),
        .irq(irq)
    );

    initial begin
        forever #25 clk = ~clk;
    end

    // ---------------------------------------------------------------
    // closing report and hang guard
    // ---------------------------------------------------------------
    task stop_test();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // whole run needs under 2000 cycles
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            err_total = err_total + 1;
            stop_test();
        end
    end

    // ---------------------------------------------------------------
    // access tasks
    // ---------------------------------------------------------------
    task chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
        checked = checked + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task rd_reg(input logic [AW-1:0] a, output logic [DW-1:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    task rd_chk(input logic [AW-1:0] a, input logic [DW-1:0] exp);
        rd_reg(a, v);
        chk(v, exp);
    endtask

    // one falling edge on a source pin, long enough for the synchroniser
    task fall(input int n);
        @(posedge clk);
        pins[n] <= 1'b0;
        repeat (6) @(posedge clk);
        pins[n] <= 1'b1;
        repeat (6) @(posedge clk);
    endtask

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk({7'h00, osc_on}, 8'h00);
        chk({7'h00, pin_out}, 8'h00);
        chk({7'h00, irq}, 8'h00);
        rd_chk(ADDR_CTRL, CTRL_RESET);
        rd_chk(ADDR_PRESET0, PRESET_RESET);
        rd_chk(ADDR_PRESET1, PRESET_RESET);
        rd_chk(ADDR_CNT_LO, COUNT_RESET);
        rd_chk(ADDR_CNT_HI, COUNT_RESET);
        rd_chk(ADDR_STATUS, 8'h00);
        rd_chk(ADDR_MASK, 8'h00);
        rd_chk(3'h7, 8'h00);
        $display("test reset_values done");

        wr_reg(ADDR_PRESET0, 8'h03);
        rd_chk(ADDR_CNT_LO, 8'h03);
        wr_reg(ADDR_CTRL, 8'h01);
        repeat (10) @(posedge clk);
        rd_chk(ADDR_CNT_LO, 8'h03);
        rd_chk(ADDR_CTRL, 8'h01);
        fall(0);
        rd_chk(ADDR_CNT_LO, 8'h03);
        fall(0);
        rd_chk(ADDR_CNT_LO, 8'h02);
        wr_reg(ADDR_CTRL, 8'h00);
        rd_chk(ADDR_CTRL, 8'h01);
        fall(0);
        rd_chk(ADDR_CNT_LO, 8'h01);
        rd_chk(ADDR_CTRL, 8'h00);
        fall(0);
        rd_chk(ADDR_CNT_LO, 8'h01);
        $display("test run_stop done");

        wr_reg(ADDR_PRESET0, 8'h02);
        wr_reg(ADDR_CTRL, 8'h01);
        repeat (3) fall(0);
        rd_chk(ADDR_CNT_LO, 8'h00);
        fall(0);
        rd_chk(ADDR_CNT_LO, 8'h02);
        chk({7'h00, irq}, 8'h00);
        chk({7'h00, pin_out}, 8'h00);
        wr_reg(ADDR_CTRL, 8'h11);
        #1 chk({7'h00, pin_out}, 8'h01);
        wr_reg(ADDR_MASK, 8'h01);
        #1 chk({7'h00, irq}, 8'h01);
        rd_chk(ADDR_STATUS, 8'h01);
        chk({7'h00, irq}, 8'h00);
        rd_chk(ADDR_STATUS, 8'h00);
        repeat (3) fall(0);
        chk({7'h00, pin_out}, 8'h00);
        chk({7'h00, irq}, 8'h01);
        repeat (3) fall(0);
        chk({7'h00, pin_out}, 8'h01);
        rd_chk(ADDR_STATUS, 8'h01);
        wr_reg(ADDR_CTRL, 8'h00);
        #1 chk({7'h00, pin_out}, 8'h00);
        fall(0);
        $display("test underflow done");

        wr_reg(ADDR_PRESET0, 8'h02);
        wr_reg(ADDR_CTRL, 8'h41);
        repeat (2) fall(1);
        rd_chk(ADDR_CNT_LO, 8'h02);
        chk({7'h00, osc_on}, 8'h00);
        wr_reg(ADDR_CTRL, 8'h61);
        #1 chk({7'h00, osc_on}, 8'h01);
        repeat (2) fall(1);
        rd_chk(ADDR_CNT_LO, 8'h01);
        wr_reg(ADDR_CTRL, 8'h60);
        fall(1);
        wr_reg(ADDR_CTRL, 8'h00);
        $display("test fast_source done");

        wr_reg(ADDR_PRESET0, 8'h04);
        wr_reg(ADDR_CTRL, 8'h09);
        rd_chk(ADDR_CTRL, 8'h09);
        fall(2);
        rd_chk(ADDR_CNT_LO, 8'h03);
        wr_reg(ADDR_CTRL, 8'h08);
        rd_chk(ADDR_CTRL, 8'h08);
        fall(2);
        rd_chk(ADDR_CNT_LO, 8'h03);
        wr_reg(ADDR_CTRL, 8'h00);
        $display("test event_mode done");

        // zero low preset: the low byte underflows on every tick
        wr_reg(ADDR_PRESET0, 8'h00);
        wr_reg(ADDR_PRESET1, 8'h40);
        wr_reg(ADDR_CTRL, 8'h07);
        repeat (4) fall(0);
        rd_chk(ADDR_CNT_LO, 8'h00);
        rd_reg(ADDR_CNT_HI, h);
        chk(h, 8'h3d);
        fall(0);
        rd_chk(ADDR_CNT_LO, 8'h00);
        fall(0);
        rd_chk(ADDR_CNT_HI, 8'h3c);
        chk({7'h00, irq}, 8'h01);
        rd_chk(ADDR_STATUS, 8'h01);
        wr_reg(ADDR_CTRL, 8'h04);
        fall(0);
        wr_reg(ADDR_CTRL, 8'h00);
        $display("test cascade done");
        stop_test();
    end
endmodule
